// *** bench/scrs_card_model.sv ***
`default_nettype none
// card in the socket: glitches early, answers at a fixed card clock count
module scrs_card_model #(
   parameter int E1 = 100, // glitch before the answer window
   parameter int E2 = 500  // real answer
) (
   input  wire logic ven_i, // card supply
   input  wire logic clk_i, // card clock
   output logic      rx_o,  // receive line, pulled up
   output int        cnt_o  // clock rises since supply on
);
   timeunit 1ns;
   timeprecision 1ns;
   // only the supplied clock is counted, never bit timing
   always @(posedge clk_i or negedge ven_i) begin
      cnt_o <= ven_i ? cnt_o + 1 : 0;
   end
   // high from 200 on except the answer; the pull-up holds it when unpowered
   assign rx_o = !(ven_i && (cnt_o inside {[E1:E1+1], [E2:E2+3]}));
endmodule : scrs_card_model
`default_nettype wire

// *** bench/scrs_seq_props.sv ***
`default_nettype none
// port checker for the card reset and power-down sequencer
module scrs_seq_props
   import scrs_pkg::*;
(
   input wire logic             clk_i,          // module clock
   input wire logic             nrst_i,         // sync reset, low active
   input wire logic             ratio16_i,      // ratio select
   input wire logic             low_rst_card_i, // reset style of card
   input wire logic [DIV_W-1:0] half_div_i,     // card clock half period
   input var  scrs_pins_s       pins_o,         // card pins
   input wire logic [8:0]       ratio_o,        // ratio in use
   input var  scrs_state_e      state_o,        // sequencer state
   input var  scrs_evt_s        evt_o           // event pulses
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic [CNT_W-1:0] ccnt_r;
   logic [CNT_W-1:0] ccnt_nxt;
   logic             cq_r;
   // card clock rises since T0, cleared in the off and clock-enable states
   always_comb begin
      ccnt_nxt = ccnt_r;
      if (state_o == ST_OFF || state_o == ST_CLKON) begin
         ccnt_nxt = '0;
      end else if (pins_o.clk && !cq_r) begin
         ccnt_nxt = ccnt_r + 16'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      ccnt_r <= nrst_i ? ccnt_nxt : '0;
      cq_r   <= nrst_i & pins_o.clk;
   end
   AST_RATIO: assert property (ratio_o == (ratio16_i ? RATIO_16 : RATIO_372))
      else $error("ratio output wrong");
   AST_CLKON: assert property ((state_o == ST_CLKON) |->
      (pins_o.ven && pins_o.tx && !pins_o.clk) ##1 (state_o == ST_WAIT))
      else $error("clock enable step wrong");
   // one count of slack: the sequencer may count the rise one cycle apart
   AST_RST_LVL: assert property ((state_o == ST_WAIT && ccnt_r < 16'h9C3F) |->
      (pins_o.rst == !low_rst_card_i))
      else $error("card reset level wrong before 40000 cycles");
   AST_ANS_MIN: assert property (evt_o.answer |-> (ccnt_r >= 16'h018F))
      else $error("answer accepted before 400 cycles");
   AST_EVT_PULSE: assert property ((evt_o != '0) |=> (evt_o == '0))
      else $error("event longer than one cycle");
   AST_TX_ORDER: assert property ((state_o == ST_PD && $fell(pins_o.tx)) |->
      !(pins_o.rst || pins_o.clk))
      else $error("transmit dropped before reset or clock");
   AST_VEN_LAST: assert property ($fell(pins_o.ven) |->
      !(pins_o.rst || pins_o.clk || pins_o.tx) && evt_o.pd_done)
      else $error("supply dropped out of order");
   // holds for reference periods of eight module clocks or longer
   AST_TX_GAP: assert property ((state_o == ST_PD && $fell(pins_o.rst)) |=>
      pins_o.tx [*8])
      else $error("transmit dropped too soon after reset");
   AST_DUTY: assert property (($rose(pins_o.clk) && half_div_i == 12'h005) |->
      ##1 (pins_o.clk || state_o == ST_PD) [*4] ##1 !pins_o.clk)
      else $error("card clock high time wrong");
endmodule : scrs_seq_props
bind scrs_seq scrs_seq_props i_scrs_seq_props (.clk_i(clk_i), .nrst_i(nrst_i),
   .ratio16_i(ratio16_i), .low_rst_card_i(low_rst_card_i), .half_div_i(half_div_i),
   .pins_o(pins_o), .ratio_o(ratio_o), .state_o(state_o), .evt_o(evt_o));
`default_nettype wire

// *** bench/testbench.sv ***
`default_nettype none
module testbench
   import scrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        start_i = 1'b0;
   logic        pd_req_i = 1'b0;
   logic        ratio16_i = 1'b0;
   logic        slow_i = 1'b0;
   logic        pres_i = 1'b0;
   logic        tx_d = 1'b1;
   logic        rx, rx_s, bd_o, bd_oe;
   logic [8:0]  ratio;
   scrs_pins_s  pins;
   scrs_state_e st;
   scrs_evt_s   evt;
   int          cnt;
   int          n_fail = 0;
   int          num_checks = 0;
   // module clock and a slow reference of unrelated phase
   always #10 clk_i = ~clk_i;
   initial #7 forever #80 slow_i = ~slow_i;
   scrs_seq i_scrs_seq (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .start_i(start_i),
      .pd_req_i(pd_req_i), .low_rst_card_i(1'b0), .half_div_i(12'h005), .bidir_i(1'b0),
      .slow_reference_clock_i(slow_i), .card_presence_detect_i(pres_i), .rx_i(rx),
      .bidir_card_data_i(1'b1), .tx_data_i(tx_d), .bidir_card_data_o(bd_o),
      .bidir_card_data_oe_o(bd_oe), .pins_o(pins), .rx_o(rx_s), .ratio_o(ratio),
      .ratio16_i(ratio16_i), .state_o(st), .evt_o(evt));
   scrs_card_model i_scrs_card_model (.ven_i(pins.ven), .clk_i(pins.clk), .rx_o(rx),
      .cnt_o(cnt));
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   // inputs move a fixed 2 ns after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : step
   // power a present card and wait for its answer; the early glitch must not count
   task automatic power_up;
      int i;
      start_i = 1'b1;
      step(2);
      chk(32'(pins.ven & pins.tx), 1, "supply not raised");
      for (i = 0; i < 20000 && evt.answer !== 1'b1; i++) begin
         step(1);
      end
      if (i == 20000) begin
         n_fail++;
         stop_test();
      end
      chk(32'(cnt >= 400 && cnt < 504), 1, "answer outside window");
      chk(32'(rx_s), 0, "receive pin not passed on");
      step(1);
      chk(32'(st), 32'(ST_RUN), "not running");
      chk(32'(bd_oe), 0, "shared pin driven in split mode");
      chk(32'(bd_o), 1, "shared pin data wrong");
   endtask : power_up
   // last high cycle of each pin gives the drop order and spacing
   task automatic pd_watch(output int lr_o);
      int i, lr, lc, lt, lv, dn;
      {lr, lc, lt, lv, dn} = '0;
      for (i = 1; i < 80; i++) begin
         step(1);
         if (pins.rst === 1'b1) lr = i;
         if (pins.clk === 1'b1) lc = i;
         if (pins.tx === 1'b1) lt = i;
         if (pins.ven === 1'b1) lv = i;
         if (evt.pd_done === 1'b1) dn = i;
      end
      chk(32'(lr < lc && lc < lt && lt < lv), 1, "drop order");
      chk(32'(lt - lr >= 15 && lv - lr >= 22), 1, "step spacing");
      chk(32'(dn), 32'(lv + 1), "done event");
      chk(32'(st), 32'(ST_DONE), "not done");
      lr_o = lr;
   endtask : pd_watch
   task automatic t_no_card;
      start_i = 1'b1;
      step(20);
      chk(32'(st), 32'(ST_OFF), "started without card");
      start_i = 1'b0;
   endtask : t_no_card
   task automatic t_pd_sw;
      int lr;
      pres_i = 1'b1;
      step(4);
      power_up();
      // transmit data follows the bench in run state
      tx_d = 1'b0;
      step(1);
      chk(32'(pins.tx), 0, "transmit data not passed");
      chk(32'(bd_o), 0, "shared pin data not passed");
      tx_d = 1'b1;
      step(1);
      chk(32'(pins.tx), 1, "transmit data not restored");
      pd_req_i = 1'b1;
      step(1);
      pd_req_i = 1'b0;
      pd_watch(lr);
      start_i = 1'b0;
      step(3);
      chk(32'(st), 32'(ST_OFF), "not back off");
   endtask : t_pd_sw
   task automatic t_pd_rm;
      int lr;
      ratio16_i = 1'b1;
      step(1);
      chk(32'(ratio), 32'(RATIO_16), "ratio 16");
      power_up();
      pres_i = 1'b0;
      pd_watch(lr);
      // 0.9 of a 160 ns reference period is over 7 module clocks
      chk(32'(lr >= 7), 1, "reset dropped too soon after removal");
   endtask : t_pd_rm
   initial begin
      repeat (12) @(posedge clk_i);
      #2;
      nrst_i = 1'b1;
      chk(32'(pins), 0, "pins after reset");
      chk(32'(st), 32'(ST_OFF), "state after reset");
      chk(32'(ratio), 32'(RATIO_372), "ratio 372");
      t_no_card();
      t_pd_sw();
      t_pd_rm();
      stop_test();
   end
endmodule : testbench
`default_nettype wire

// *** logic/scrs_pkg.sv ***
`default_nettype none
package scrs_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ           = 50_000_000;
   localparam int unsigned CARD_CLK_MAX_HZ  = 5_000_000;
   localparam int unsigned CARD_CLK_MIN_HZ  = 10_000;
   localparam int unsigned DIV_MIN_HALF     = (CLK_HZ + 2 * CARD_CLK_MAX_HZ - 1)
                                              / (2 * CARD_CLK_MAX_HZ);
   localparam int unsigned DIV_MAX_HALF     = CLK_HZ / (2 * CARD_CLK_MIN_HZ);
   localparam int unsigned DIV_W            = 12;
   localparam logic [DIV_W-1:0] DIV_RST     = 12'(DIV_MIN_HALF);
   // card-clock cycle counts of the reset sequence
   localparam int unsigned RX_HIGH_CYC      = 200;
   localparam int unsigned ANS_MIN_CYC      = 400;
   localparam int unsigned ANS_MAX_CYC      = 40000;
   localparam int unsigned RST_LOW_CYC      = 40000;
   localparam int unsigned CNT_W            = 16;
   // clock to data-rate ratios
   localparam logic [8:0]  RATIO_372        = 9'h174;
   localparam logic [8:0]  RATIO_16         = 9'h010;

   typedef enum logic [5:0] {
      ST_OFF   = 6'h01,
      ST_CLKON = 6'h02,
      ST_WAIT  = 6'h04,
      ST_RUN   = 6'h08,
      ST_PD    = 6'h10,
      ST_DONE  = 6'h20
   } scrs_state_e;

   // card pin outputs grouped
   typedef struct packed {
      logic rst;
      logic clk;
      logic tx;
      logic ven;
   } scrs_pins_s;

   typedef struct packed {
      logic timeout;
      logic answer;
      logic pd_done;
   } scrs_evt_s;
endpackage : scrs_pkg
`default_nettype wire

// *** logic/scrs_seq.sv ***
`default_nettype none
// What this block does
// (R01) card clock from block, 372 or 16 ratio
// (R02) card clock never aligned to serial data
// (R03) one six-pin port, bidirectional data option
// (R04) pins asynchronous except reset and power-down
// (R05) clock enable marks T0 for counting
// (R06) card keeps receive high after 200 cycles
// (R07) internal-reset card answers within 400..40000
// (R08) active-low reset held 40000 cycles
// (R09) reset high at T1, answer 400..40000
// (R10) power-down order: reset, clock, tx, supply
// (R11) each power-down step one slow clock period
// (R12) power-down on removal or software request
// (R13) clock, tx, supply stop 0.9/1.8/2.7 periods later
// (R14) reset low 0.9 periods after removal
// (R15) card clock 0.01..5 MHz, 50% duty
// (R16) flag answer timeout and power-down completion
module scrs_seq
   import scrs_pkg::*;
(
   input  wire logic             clk_i,          // 50 MHz module clock
   input  wire logic             nrst_i,         // sync reset, low active
   input  wire logic             en_i,           // clock enable, freezes all state
   input  wire logic             start_i,        // software: power up and reset card
   input  wire logic             pd_req_i,       // software: power-down request
   input  wire logic             low_rst_card_i, // card uses active-low reset
   input  wire logic [DIV_W-1:0] half_div_i,     // card clock half period in clk cycles
   input  wire logic             bidir_i,        // tx and rx share bidir_card_data
   input  wire logic             slow_reference_clock_i, // about 32 kHz, async
   input  wire logic             card_presence_detect_i, // high while card present
   input  wire logic             rx_i,           // card receive pin
   input  wire logic             bidir_card_data_i,  // shared data pin input
   input  wire logic             tx_data_i,      // transmit data from the uart
   output logic                  bidir_card_data_o,  // shared data pin output
   output logic                  bidir_card_data_oe_o, // high while driving shared pin
   output scrs_pins_s            pins_o,         // card reset, clock, tx, supply enable
   output logic                  rx_o,           // synchronised receive data
   output logic [8:0]            ratio_o,        // clock to bit ratio in use
   input  wire logic             ratio16_i,      // select 16x instead of 372x
   output scrs_state_e           state_o,        // sequencer state
   output scrs_evt_s             evt_o           // one-cycle event pulses
);
   logic [3:0] sy;
   logic       slow_reference_clock_s, pres_s, rx_s, bd_s;

   // pins cross two flops before any logic [R04]
   scrs_sync #(.W(4)) u_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .en_i   (en_i),
      .d_i    ({slow_reference_clock_i, card_presence_detect_i, rx_i, bidir_card_data_i}),
      .q_o    (sy)
   );
   assign {slow_reference_clock_s, pres_s, rx_s, bd_s} = sy;

   function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
      if (d < DIV_W'(DIV_MIN_HALF))
         clamp_div = DIV_W'(DIV_MIN_HALF);
      else if (d > DIV_W'(DIV_MAX_HALF))
         clamp_div = DIV_W'(DIV_MAX_HALF);
      else
         clamp_div = d;
   endfunction : clamp_div

   scrs_state_e      st_r, st_nxt;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic             cclk_r, cclk_nxt;
   logic [CNT_W-1:0] cyc_r, cyc_nxt;     // card clock cycles since T0 or T1
   logic             t1_r, t1_nxt;       // active-low card: reset released
   logic             rst_r, rst_nxt;
   logic             clkon_r, clkon_nxt;
   logic             tx_r, tx_nxt;
   logic             ven_r, ven_nxt;
   logic [2:0]       pdstep_r, pdstep_nxt;
   logic             slow_reference_clock_d_r, slow_reference_clock_d_nxt;
   logic             pres_d_r, pres_d_nxt;
   scrs_evt_s        evt_r, evt_nxt;
   logic             slow_reference_clock_rise, cclk_rise, removed, rx_line;

   assign slow_reference_clock_rise = slow_reference_clock_s & ~slow_reference_clock_d_r;
   assign removed   = pres_d_r & ~pres_s;
   assign rx_line   = bidir_i ? bd_s : rx_s;                  // [R03]
   assign cclk_rise = clkon_r && !cclk_r && (div_r == '0);

   // card clock divider, free of any data timing [R02]
   always_comb begin
      div_nxt  = div_r;
      cclk_nxt = cclk_r;
      if (!clkon_r) begin
         div_nxt  = clamp_div(half_div_i);
         cclk_nxt = 1'b0;
      end else if (div_r == '0) begin
         div_nxt  = clamp_div(half_div_i) - DIV_W'(1);        // [R15]
         cclk_nxt = ~cclk_r;                                   // equal halves [R15]
      end else begin
         div_nxt  = div_r - DIV_W'(1);
      end
   end

   // sequencer for reset and power-down
   always_comb begin
      st_nxt     = st_r;
      cyc_nxt    = cyc_r;
      t1_nxt     = t1_r;
      rst_nxt    = rst_r;
      clkon_nxt  = clkon_r;
      tx_nxt     = tx_r;
      ven_nxt    = ven_r;
      pdstep_nxt = pdstep_r;
      evt_nxt    = '0;
      slow_reference_clock_d_nxt = slow_reference_clock_s;
      pres_d_nxt = pres_s;
      if (cclk_rise && cyc_r != '1)
         cyc_nxt = cyc_r + CNT_W'(1);
      unique case (st_r)
         ST_OFF: begin
            if (start_i && pres_s) begin
               ven_nxt = 1'b1;
               tx_nxt  = 1'b1;
               rst_nxt = 1'b0;
               st_nxt  = ST_CLKON;
            end
         end
         ST_CLKON: begin
            clkon_nxt = 1'b1;                                  // T0 [R05] [R01]
            cyc_nxt   = '0;
            t1_nxt    = 1'b0;
            rst_nxt   = ~low_rst_card_i;
            st_nxt    = ST_WAIT;
         end
         ST_WAIT: begin
            if (low_rst_card_i && !t1_r) begin
               // no answer expected while reset is low [R08]
               if (cyc_r >= CNT_W'(RST_LOW_CYC)) begin
                  rst_nxt = 1'b1;                              // T1 [R09]
                  t1_nxt  = 1'b1;
                  cyc_nxt = '0;
               end
            end else if (cyc_r >= CNT_W'(RX_HIGH_CYC) && !rx_line
                         && cyc_r >= CNT_W'(ANS_MIN_CYC)) begin
               evt_nxt.answer = 1'b1;                          // [R07] [R09]
               st_nxt         = ST_RUN;
            end else if (cyc_r > CNT_W'(ANS_MAX_CYC)) begin
               evt_nxt.timeout = 1'b1;                         // [R16]
               st_nxt          = ST_RUN;
            end
            // a low rx before cycle 400 is ignored; card keeps it high [R06]
         end
         ST_RUN: begin
            tx_nxt = tx_data_i;
         end
         ST_PD: begin
            if (slow_reference_clock_rise) begin
               pdstep_nxt = pdstep_r + 3'(1);
               unique case (pdstep_r)                          // [R10] [R11]
                  // first rise only starts a whole period, so reset never drops early
                  3'h0: rst_nxt   = rst_r;                     // [R14]
                  3'h1: rst_nxt   = 1'b0;                      // [R14]
                  3'h2: clkon_nxt = 1'b0;                      // [R13]
                  3'h3: tx_nxt    = 1'b0;                      // [R13]
                  3'h4: begin
                     ven_nxt         = 1'b0;                   // [R13]
                     evt_nxt.pd_done = 1'b1;                   // [R16]
                     st_nxt          = ST_DONE;
                  end
                  default: st_nxt = ST_DONE;
               endcase
            end
         end
         ST_DONE: begin
            if (!start_i)
               st_nxt = ST_OFF;
         end
         default: st_nxt = ST_OFF;
      endcase
      // removal or software request starts power-down [R12]
      if ((removed || pd_req_i) && st_r != ST_OFF && st_r != ST_PD && st_r != ST_DONE) begin
         st_nxt     = ST_PD;
         pdstep_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_r     <= ST_OFF;
         div_r    <= DIV_RST;
         cclk_r   <= 1'b0;
         cyc_r    <= '0;
         t1_r     <= 1'b0;
         rst_r    <= 1'b0;
         clkon_r  <= 1'b0;
         tx_r     <= 1'b0;
         ven_r    <= 1'b0;
         pdstep_r <= '0;
         slow_reference_clock_d_r <= 1'b0;
         pres_d_r <= 1'b0;
         evt_r    <= '0;
      end else if (en_i) begin
         st_r     <= st_nxt;
         div_r    <= div_nxt;
         cclk_r   <= cclk_nxt;
         cyc_r    <= cyc_nxt;
         t1_r     <= t1_nxt;
         rst_r    <= rst_nxt;
         clkon_r  <= clkon_nxt;
         tx_r     <= tx_nxt;
         ven_r    <= ven_nxt;
         pdstep_r <= pdstep_nxt;
         slow_reference_clock_d_r <= slow_reference_clock_d_nxt;
         pres_d_r <= pres_d_nxt;
         evt_r    <= evt_nxt;
      end
   end

   // outputs; shared pin released while card answers
   assign pins_o.rst           = rst_r;
   assign pins_o.clk           = cclk_r;
   assign pins_o.tx            = tx_r;
   assign pins_o.ven           = ven_r;
   assign bidir_card_data_o    = tx_r;
   assign bidir_card_data_oe_o = bidir_i && ven_r && (st_r == ST_RUN || st_r == ST_PD) && !tx_r;
   assign rx_o                 = rx_line;
   assign ratio_o              = ratio16_i ? RATIO_16 : RATIO_372;  // [R01]
   assign state_o              = st_r;
   assign evt_o                = evt_r;
endmodule : scrs_seq
`default_nettype wire

// *** logic/scrs_sync.sv ***
`default_nettype none
// two-flop synchroniser for pins from outside the clock domain
module scrs_sync
   import scrs_pkg::*;
#(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,   // module clock
   input  wire logic         nrst_i,  // sync reset, low active
   input  wire logic         en_i,    // clock enable
   input  wire logic [W-1:0] d_i,     // async input
   output logic      [W-1:0] q_o      // synchronised output
);
   logic [W-1:0] s1_r, s1_nxt, s2_r, s2_nxt;

   // first stage read only by the second
   always_comb begin
      s1_nxt = d_i;
      s2_nxt = s1_r;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s1_r <= '0;
         s2_r <= '0;
      end else if (en_i) begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   assign q_o = s2_r;
endmodule : scrs_sync
`default_nettype wire
